// >>> rtl/polseq_map.vh
// Constants for the point-of-load voltage sequencer.
// Assumes a 20 MHz reference clock and a 12-bit trim DAC and ADC.
`ifndef POLSEQ_MAP_VH
`define POLSEQ_MAP_VH
`define POLSEQ_CLK_HZ       20000000
`define POLSEQ_TICK_US      10
// Clock cycles per 10 us tick at 20 MHz.
`define POLSEQ_TICK_CYC     16'h00c8
`define POLSEQ_CORR_MAX_HZ  10000
// Smallest correction interval setting; corrections then come 11 ticks apart, under the 10 kHz ceiling.
`define POLSEQ_CORR_MIN_TK  16'h000a
`define POLSEQ_DAC_W        12
`define POLSEQ_DAC_RST      12'h000
`define POLSEQ_CNT_W        16
`endif

// >>> rtl/polseq_sequencer.v
// Sequencing and closed-loop trim of a point-of-load supply.
// Assumes settings come from registers on ref_clk and the ADC results
// arrive as ref_clk pulses; the on/off pin is asynchronous.
// Notes on behaviour
// RULE_01: Start sequence on bus on command or on/off pin turn-on level.
// RULE_02: Reference mode: after on-delay enable output, ramp DAC to target.
// RULE_03: After target, correct DAC one LSB up or down per correction.
// RULE_04: Corrections paced by correction interval, up to 10 kHz.
// RULE_05: Reference mode margin moves at margin slew in one-LSB steps.
// RULE_06: Loop divider ratio scales step count and step size.
// RULE_07: Reference mode off: wait off-delay, ramp to zero, drop enable.
// RULE_08: Feedback mode: after on-delay enable output, supply ramps itself.
// RULE_09: Feedback mode: connect switch open during whole rise time.
// RULE_10: Feedback mode: seed DAC from ADC of DAC pin, then connect.
// RULE_11: Host must program nonzero on-delay and rise time in feedback mode.
// RULE_12: Feedback mode off: wait off-delay, drop enable, no DAC ramp.
// RULE_13: Feedback mode ignores margin slew; margin uses single steps.
// RULE_14: Host keeps commanded DAC voltage within 30 mV to 2 V.
// RULE_15: Sensed output reaches 12-bit ADC through mux; used for regulation.
// RULE_16: Turn-off during startup abandons it and shuts down from present DAC.
// RULE_17: All timing counts in ticks of one internal time base.
`include "polseq_map.vh"
`default_nettype none
module polseq_sequencer (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        clkEn,
  input  wire        feedbackNodeMode,
  input  wire        busOnCmd,
  input  wire        busOffCmd,
  input  wire        onoffControlPin,
  input  wire        onoffPinEnable,
  input  wire [11:0] targetVoltageSetting,
  input  wire [11:0] marginTarget,
  input  wire        marginRequest,
  input  wire [15:0] turnOnDelay,
  input  wire [15:0] riseTime,
  input  wire [15:0] turnOffDelay,
  input  wire [15:0] fallTime,
  input  wire [15:0] correctionRateSetting,
  input  wire [15:0] marginSlewRate,
  input  wire [7:0]  loopDividerRatio,
  input  wire [11:0] adcResult,
  input  wire        adcValid,
  output reg         adcMuxSelDacPin,
  output reg         powerEnableOut,
  output reg         powerEnableOutOe,
  output reg  [11:0] trimDacOut,
  output reg         dacConnectSwitch,
  output reg         targetReached,
  output reg  [2:0]  seqState
);
  localparam [2:0] ST_OFF  = 3'h0;
  localparam [2:0] ST_OND  = 3'h1;
  localparam [2:0] ST_RISE = 3'h2;
  localparam [2:0] ST_SEED = 3'h3;
  localparam [2:0] ST_REG  = 3'h4;
  localparam [2:0] ST_OFFD = 3'h5;
  localparam [2:0] ST_FALL = 3'h6;
  localparam [15:0] TICK_CYC = `POLSEQ_TICK_CYC;
  localparam [15:0] CORR_MIN = `POLSEQ_CORR_MIN_TK;

  reg [2:0]  pinSync;
  reg        pinLevel;
  reg [15:0] prescale;
  reg        tick;
  reg [15:0] timer;
  reg [15:0] stepTimer;
  reg [15:0] stepInterval;
  reg [11:0] stepSize;
  reg [11:0] rampGoal;
  reg        onReq;
  reg        offReq;
  reg        ramping;
  reg        seedArmed;
  reg [11:0] sensedOut;

  wire [15:0] corrIval = (correctionRateSetting < CORR_MIN) ?
                         CORR_MIN : correctionRateSetting; // RULE_04
  wire [11:0] regGoal  = marginRequest ? marginTarget : targetVoltageSetting;
  wire [11:0] diff     = (rampGoal > trimDacOut) ? rampGoal - trimDacOut :
                         trimDacOut - rampGoal;
  wire [11:0] stepMove = (diff < stepSize) ? diff : stepSize;
  wire [19:0] scaledMv = {8'h00, regGoal} * {12'h000, loopDividerRatio};
  wire [11:0] dacGoal  = scaledMv[19:8]; // RULE_06

  // Pin level filter: counted once the second and third stages agree.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pinSync  <= 3'h0;
      pinLevel <= 1'b0;
    end else if (clkEn) begin
      pinSync <= {pinSync[1:0], onoffControlPin};
      if (pinSync[1] == pinSync[2])
        pinLevel <= pinSync[2];
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prescale <= 16'h0000;
      tick     <= 1'b0;
    end else if (clkEn) begin
      tick <= (prescale == TICK_CYC - 16'h0001); // RULE_17
      if (prescale == TICK_CYC - 16'h0001)
        prescale <= 16'h0000;
      else
        prescale <= prescale + 16'h0001;
    end
  end

  always @* begin
    onReq  = busOnCmd | (onoffPinEnable & pinLevel); // RULE_01
    offReq = busOffCmd | (onoffPinEnable & ~pinLevel & ~busOnCmd);
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      seqState         <= ST_OFF;
      timer            <= 16'h0000;
      stepTimer        <= 16'h0000;
      stepInterval     <= 16'h0001;
      stepSize         <= 12'h001;
      rampGoal         <= `POLSEQ_DAC_RST;
      ramping          <= 1'b0;
      seedArmed        <= 1'b0;
      trimDacOut       <= `POLSEQ_DAC_RST;
      dacConnectSwitch <= 1'b0;
      powerEnableOut   <= 1'b0;
      powerEnableOutOe <= 1'b1;
      targetReached    <= 1'b0;
      adcMuxSelDacPin  <= 1'b0;
      sensedOut        <= 12'h000;
    end else if (clkEn) begin
      powerEnableOutOe <= ~powerEnableOut;
      if (adcValid && !adcMuxSelDacPin)
        sensedOut <= adcResult; // RULE_15
      if (tick && timer != 16'h0000)
        timer <= timer - 16'h0001;
      if (tick && stepTimer != 16'h0000)
        stepTimer <= stepTimer - 16'h0001;
      // A DAC ramp: one step of up to stepSize each stepInterval+1 ticks.
      if (ramping && tick && stepTimer == 16'h0000) begin
        stepTimer <= stepInterval;
        if (diff == 12'h000)
          ramping <= 1'b0;
        else if (rampGoal > trimDacOut)
          trimDacOut <= trimDacOut + stepMove;
        else
          trimDacOut <= trimDacOut - stepMove;
      end
      case (seqState)
        ST_OFF: begin
          targetReached <= 1'b0;
          if (onReq) begin
            seqState <= ST_OND;
            timer    <= turnOnDelay;
          end
        end
        ST_OND: begin
          if (offReq) begin
            seqState <= ST_OFFD; // RULE_16
            timer    <= turnOffDelay;
          end else if (timer == 16'h0000) begin
            powerEnableOut <= 1'b1; // RULE_02 RULE_08
            timer          <= riseTime;
            seqState       <= ST_RISE;
            if (!feedbackNodeMode) begin
              dacConnectSwitch <= 1'b1;
              rampGoal         <= dacGoal;
              stepInterval     <= 16'h0000;
              stepTimer        <= 16'h0000;
              ramping          <= 1'b1;
              // Step size so the goal lands at the end of the rise time.
              stepSize <= (riseTime == 16'h0000) ? dacGoal :
                          ((dacGoal / riseTime[11:0]) + 12'h001); // RULE_06
            end else
              dacConnectSwitch <= 1'b0; // RULE_09
          end
        end
        ST_RISE: begin
          if (offReq) begin
            seqState <= ST_OFFD; // RULE_16
            timer    <= turnOffDelay;
            ramping  <= 1'b0;
          end else if (timer == 16'h0000) begin
            if (feedbackNodeMode) begin
              adcMuxSelDacPin <= 1'b1;
              seedArmed       <= 1'b0;
              seqState        <= ST_SEED;
            end else begin
              trimDacOut    <= dacGoal; // RULE_02
              ramping       <= 1'b0;
              targetReached <= 1'b1;
              seqState      <= ST_REG;
            end
          end
        end
        ST_SEED: begin
          // A result already in flight when the mux moved is of the sense
          // input, so the first cycle here never takes a seed.
          seedArmed <= 1'b1;
          if (adcValid && seedArmed) begin
            trimDacOut       <= adcResult; // RULE_10
            dacConnectSwitch <= 1'b1;
            adcMuxSelDacPin  <= 1'b0;
            targetReached    <= 1'b1;
            stepTimer        <= corrIval;
            seqState         <= ST_REG;
          end else if (offReq) begin
            adcMuxSelDacPin <= 1'b0;
            seqState        <= ST_OFFD;
            timer           <= turnOffDelay;
          end
        end
        ST_REG: begin
          if (offReq) begin
            seqState <= ST_OFFD;
            timer    <= turnOffDelay;
            ramping  <= 1'b0;
          end else if (!feedbackNodeMode && marginRequest &&
                       dacGoal != rampGoal) begin
            rampGoal     <= dacGoal; // RULE_05
            stepSize     <= 12'h001;
            stepInterval <= marginSlewRate;
            ramping      <= 1'b1;
          end else if (!ramping && tick && stepTimer == 16'h0000) begin
            stepTimer <= corrIval; // RULE_04 RULE_13
            if (sensedOut < regGoal && trimDacOut != 12'hfff)
              trimDacOut <= trimDacOut + 12'h001; // RULE_03
            else if (sensedOut > regGoal && trimDacOut != 12'h000)
              trimDacOut <= trimDacOut - 12'h001; // RULE_03
          end
        end
        ST_OFFD: begin
          targetReached <= 1'b0;
          if (timer == 16'h0000) begin
            if (feedbackNodeMode || !dacConnectSwitch) begin
              powerEnableOut   <= 1'b0; // RULE_12
              dacConnectSwitch <= 1'b0;
              seqState         <= ST_OFF;
            end else begin
              rampGoal     <= 12'h000; // RULE_07
              stepInterval <= 16'h0000;
              stepSize     <= (fallTime == 16'h0000) ? trimDacOut :
                              ((trimDacOut / fallTime[11:0]) + 12'h001);
              ramping      <= 1'b1;
              timer        <= fallTime;
              seqState     <= ST_FALL;
            end
          end
        end
        ST_FALL: begin
          if (timer == 16'h0000 || (trimDacOut == 12'h000 && !ramping)) begin
            trimDacOut       <= 12'h000;
            ramping          <= 1'b0;
            powerEnableOut   <= 1'b0; // RULE_07
            dacConnectSwitch <= 1'b0;
            seqState         <= ST_OFF;
          end
        end
        default: seqState <= ST_OFF;
      endcase
    end
  end
endmodule // polseq_sequencer
`default_nettype wire

// >>> tb/polseq_supply_model.sv
// Behavioural point-of-load supply seen through the ADC input path.
// Assumes one ref_clk domain; conversions finish every 40 cycles.
`default_nettype none
module polseq_supply_model #(
  parameter logic [11:0] FB_LEVEL    = 12'h4b0,
  parameter logic [11:0] SENSE_LEVEL = 12'h3f0
) (
  input  wire logic        ref_clk,
  input  wire logic        powerEnableOut,
  input  wire logic        dacConnectSwitch,
  input  wire logic        adcMuxSelDacPin,
  input  wire logic [11:0] trimDacOut,
  output var  logic [11:0] adcResult,
  output var  logic        adcValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] convCnt = 6'h00;
  always @(posedge ref_clk) begin
    convCnt <= (convCnt == 6'h27) ? 6'h00 : convCnt + 6'h01;
    adcValid <= (convCnt == 6'h27);
    // An open switch lets the pin float to the feedback node.
    if (adcMuxSelDacPin) begin
      adcResult <= dacConnectSwitch ? trimDacOut : FB_LEVEL;
    end else begin
      adcResult <= powerEnableOut ? SENSE_LEVEL : 12'h000;
    end
  end
endmodule // polseq_supply_model
`default_nettype wire

// >>> tb/polseq_props.sv
// Port-level checker for the sequencer.
// Assumes it is bound to polseq_sequencer and sees only its ports.
`default_nettype none
module polseq_props (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        feedbackNodeMode,
  input wire logic        busOnCmd,
  input wire logic        busOffCmd,
  input wire logic        marginRequest,
  input wire logic [11:0] targetVoltageSetting,
  input wire logic [7:0]  loopDividerRatio,
  input wire logic        powerEnableOut,
  input wire logic [11:0] trimDacOut,
  input wire logic        dacConnectSwitch,
  input wire logic        targetReached,
  input wire logic [2:0]  seqState
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire [19:0] goal = targetVoltageSetting * loopDividerRatio;
  property p_start; $rose(busOnCmd) && !busOffCmd && clkEn
    && seqState == 3'd0 |-> ##[1:4] seqState == 3'd1; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_reach; $rose(targetReached) && !feedbackNodeMode
    && !marginRequest |-> trimDacOut == goal[19:8]; endproperty
  a_reach: assert property (p_reach) else $error("ramp end code");
  property p_step; seqState == 3'd4 && $past(seqState) == 3'd4
    && $changed(trimDacOut)
    |-> (trimDacOut - $past(trimDacOut)) inside {12'h001, 12'hfff};
  endproperty
  a_step: assert property (p_step) else $error("step not one LSB");
  property p_pace; seqState == 3'd4 && $past(seqState) == 3'd4
    && $changed(trimDacOut)
    |=> ($stable(trimDacOut) || seqState != 3'd4) [*8]; endproperty
  a_pace: assert property (p_pace) else $error("corrections too fast");
  property p_enRise; $rose(powerEnableOut) |-> seqState == 3'd2; endproperty
  a_enRise: assert property (p_enRise) else $error("enable off rise");
  property p_fbOpen; feedbackNodeMode && seqState == 3'd2
    |-> !dacConnectSwitch; endproperty
  a_fbOpen: assert property (p_fbOpen) else $error("switch closed");
  property p_seed; $rose(dacConnectSwitch) && feedbackNodeMode
    |-> $past(seqState) == 3'd3; endproperty
  a_seed: assert property (p_seed) else $error("switch before seed");
  property p_fbNoFall; feedbackNodeMode && seqState == 3'd5
    |=> seqState != 3'd6; endproperty
  a_fbNoFall: assert property (p_fbNoFall) else $error("fb fall ramp");
  property p_refOff; $fell(powerEnableOut) && !feedbackNodeMode
    |-> trimDacOut == 12'h000; endproperty
  a_refOff: assert property (p_refOff) else $error("dac not zero");
  property p_offWins; busOffCmd && !busOnCmd && clkEn
    && seqState inside {3'd1, 3'd2}
    |-> ##[1:4] seqState inside {3'd0, 3'd5, 3'd6}; endproperty
  a_offWins: assert property (p_offWins) else $error("off ignored");
  cover property (seqState == 3'd4 && feedbackNodeMode);
  cover property (seqState == 3'd4 && !feedbackNodeMode);
  cover property ($fell(powerEnableOut));
endmodule // polseq_props
bind polseq_sequencer polseq_props u_props (.*);
`default_nettype wire

// >>> tb/polseq_sequencer_tb_top.sv
// Self-checking bench for the sequencer with a supply model.
// Assumes delays in 200-cycle ticks and a 50 ns reference clock.
`default_nettype none
module polseq_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_b = 0, clkEn = 1, feedbackNodeMode = 0;
  logic busOnCmd = 0, busOffCmd = 0, onoffControlPin = 0;
  logic onoffPinEnable = 0, marginRequest = 0;
  logic [11:0] targetVoltageSetting = 12'h400, marginTarget = 12'h000;
  logic [15:0] turnOnDelay = 16'h0002, riseTime = 16'h0004;
  logic [15:0] turnOffDelay = 16'h0002, fallTime = 16'h0004;
  logic [15:0] correctionRateSetting = 16'h000a, marginSlewRate = 16'h0002;
  logic [7:0] loopDividerRatio = 8'h80;
  logic adcMuxSelDacPin, powerEnableOut, powerEnableOutOe, adcValid;
  logic dacConnectSwitch, targetReached;
  logic [11:0] trimDacOut, adcResult;
  logic [2:0] seqState;
  logic [11:0] dacMark;
  logic marginOk;
  int num_errors = 0;
  int n_tests = 0;
  polseq_sequencer dut (.*);
  polseq_supply_model model (.*);
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [11:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic waitCond(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (sel == 0 && targetReached === 1'b1 || sel == 1 &&
          powerEnableOut === 1'b0 || sel == 2 && dacConnectSwitch === 1'b1
          || sel == 3 && seqState === 3'd0) break;
      @(negedge ref_clk);
    end
    chk("wait done", {11'h000, i < lim}, 12'h001);
  endtask
  task automatic setCmd(input logic on);
    busOnCmd = on;
    busOffCmd = !on;
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_b = 1;
    setCmd(1);
    waitCond(0, 3000);
    chk("ref ramp end", trimDacOut, 12'h200);
    chk("ref enable", {11'h000, powerEnableOut}, 12'h001);
    chk("enable oe", {11'h000, powerEnableOutOe}, 12'h000);
    repeat (5000) @(negedge ref_clk);
    dacMark = trimDacOut;
    marginTarget = 12'h420;
    marginRequest = 1;
    repeat (6000) @(negedge ref_clk);
    marginOk = (trimDacOut - dacMark) >= 12'h004 &&
               (trimDacOut - dacMark) <= 12'h00b;
    chk("margin steps", {11'h000, marginOk}, 12'h001);
    marginRequest = 0;
    setCmd(0);
    waitCond(1, 4000);
    chk("ref off dac", trimDacOut, 12'h000);
    @(negedge ref_clk);
    chk("off oe", {11'h000, powerEnableOutOe}, 12'h001);
    setCmd(1);
    repeat (700) @(negedge ref_clk);
    setCmd(0);
    waitCond(3, 4000);
    chk("abort enable", {11'h000, powerEnableOut}, 12'h000);
    busOffCmd = 0;
    onoffPinEnable = 1;
    onoffControlPin = 1;
    waitCond(0, 3000);
    chk("pin ramp end", trimDacOut, 12'h200);
    onoffControlPin = 0;
    waitCond(1, 4000);
    chk("pin off dac", trimDacOut, 12'h000);
    onoffPinEnable = 0;
    feedbackNodeMode = 1;
    setCmd(1);
    waitCond(2, 4000);
    chk("fb seed", trimDacOut, 12'h4b0);
    chk("fb mux back", {11'h000, adcMuxSelDacPin}, 12'h000);
    repeat (3000) @(negedge ref_clk);
    setCmd(0);
    waitCond(1, 700);
    report_and_stop;
  end
  initial begin
    #2000000;
    num_errors++;
    report_and_stop;
  end
endmodule // polseq_sequencer_tb_top
`default_nettype wire
